// ===== glitch_filter.v
// Input glitch filter with selectable number of stable clock cycles
`timescale 1ns/1ps
`include "ir_ctrl_consts.vh"
module glitch_filter #(
    parameter CW = 4
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       raw_in,
    input  wire [1:0] filter_sel,
    output reg        clean_out
);
    reg  [CW-1:0] stable_count;
    reg           last_raw;
    wire [CW-1:0] need = (filter_sel == 2'b01) ? `FILTER_SHORT : `FILTER_LONG;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stable_count <= {CW{1'b0}};
            last_raw     <= 1'b0;
            clean_out    <= 1'b0;
        end
        else
        begin
            last_raw <= raw_in;
            if (raw_in != last_raw)
                stable_count <= {CW{1'b0}};
            else if (stable_count != {CW{1'b1}})
                stable_count <= stable_count + 1'b1;
            // Level passes only after it has held for the chosen count [R7]
            if (filter_sel == 2'b00 || filter_sel == 2'b11)
                clean_out <= raw_in;
            else if (raw_in == last_raw && stable_count + 1'b1 >= need - 1'b1)
                clean_out <= raw_in;
        end
    end
endmodule

// ===== ir_ctrl_checker.sv
// Port-level checks of the common timer control block
`timescale 1ns/1ps
module ir_ctrl_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        short_timer_done,
    input wire        long_timer_done,
    input wire        ping_pong_active,
    input wire        pp_short_enable,
    input wire        pp_long_enable,
    input wire        long_force_en
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ************************************************
    // Assertions and cover points
    // ************************************************
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response held after handshake");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_short_to_long: assert property (ping_pong_active && short_timer_done && !long_timer_done
        |=> pp_long_enable && !pp_short_enable)
        else $error("short done did not hand over");
    a_long_to_short: assert property (ping_pong_active && long_timer_done && !short_timer_done
        |=> pp_short_enable && !pp_long_enable)
        else $error("long done did not hand back");
    a_force_excl: assert property (long_force_en |-> !$past(ping_pong_active))
        else $error("force and ping-pong together");
    c_handover: cover property (ping_pong_active && short_timer_done);
    c_force: cover property (long_force_en);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== ir_ctrl_consts.vh
// Offsets, field positions, reset values and timing counts of the common timer control
`ifndef IR_CTRL_CONSTS_VH
`define IR_CTRL_CONSTS_VH
`define CTRL_OFFSET      4'h4
`define CTRL_INDEX       8'h01
`define STAT_OFFSET      4'h8
`define CTRL_RESET       8'h00
`define BIT_MODE         7
`define BIT_ROUTE        6
`define BIT_LOGIC_HI     5
`define BIT_LOGIC_LO     4
`define BIT_OUTF_HI      3
`define BIT_OUTF_LO      2
`define BIT_RISE         1
`define BIT_FALL         0
`define FILTER_SHORT     4'd4
`define FILTER_LONG      4'd8
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// ===== ir_pin_partner.sv
// Demodulator input pins as driven by an IR receiver, idle high
`timescale 1ns/1ps
module ir_pin_partner (
    input  wire aclk,
    output reg  pin_a,
    output reg  pin_b
);
    initial
    begin
        pin_a = 1'b1;
        pin_b = 1'b1;
    end
    // Low burst on one pin; the other stays idle
    task pulse(input sel, input integer n);
        integer k;
        begin
            @(posedge aclk);
            if (sel) pin_b <= 1'b0;
            else pin_a <= 1'b0;
            for (k = 0; k < n; k = k + 1)
                @(posedge aclk);
            if (sel) pin_b <= 1'b1;
            else pin_a <= 1'b1;
        end
    endtask
endmodule

// ===== ir_timer_common_control.v
// Common control register of the short and long IR timer pair, AXI4-Lite slave
//
// What this block does
// R1: Top bit picks mode: 0 carrier transmit, 1 demodulation; transmit after reset.
// R2: Transmit: routing bit 0 leaves pin as port output, 1 drives combined output.
// R3: Demodulation: routing bit 0 takes input pin a, 1 takes pin b.
// R4: Transmit: logic field 00 AND, 01 OR, 10 NOR, 11 NAND.
// R5: Demodulation: edge field 00 falling, 01 rising, 10 both, 11 reserved.
// R6: Transmit: output field normal, ping-pong, force long output low, force high.
// R7: Demodulation: filter field none, 4 cycles, 8 cycles, reserved.
// R8: Transmit: bit 1 sets initial short timer output level.
// R9: Demodulation: bit 1 flags rising edge; write 1 clears, 0 keeps.
// R10: Transmit: bit 0 sets initial long timer output level.
// R11: Demodulation: bit 0 flags falling edge; write 1 clears, 0 keeps.
// R12: Software stops both timers before changing mode.
// R13: Ping-pong: short done enables long; long done re-enables short, repeating.
// R14: Software sets single-pass first; writing 00 stops ping-pong.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "ir_ctrl_consts.vh"
module ir_timer_common_control (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        short_timer_output,
    input  wire        long_timer_output,
    input  wire        short_timer_done,
    input  wire        long_timer_done,
    input  wire        port_data_out,
    input  wire        demod_input_pin_a,
    input  wire        demod_input_pin_b,
    output reg         carrier_output_pin,
    output reg         short_timer_init_level,
    output reg         long_timer_init_level,
    output reg         long_force_en,
    output reg         long_force_level,
    output wire        ping_pong_active,
    output wire        pp_short_enable,
    output wire        pp_long_enable,
    output reg         demod_edge,
    output reg         demod_level
);
    // ************************************************************
    // Register state
    // ************************************************************
    reg        mode;
    reg        route;
    reg  [1:0] logic_sel;
    reg  [1:0] out_sel;
    // Start levels; stored only by writes whose mode bit selects transmit
    reg        bit1_tx;
    reg        bit0_tx;
    reg        aw_held;
    reg  [3:0] aw_addr;
    reg        w_held;
    reg  [7:0] w_byte;
    reg        w_lane;
    reg        filt_last;
    reg        combined;

    wire       filt_in;
    wire       demod_raw;
    wire       rise_evt;
    wire       fall_evt;
    wire       do_write;
    wire       ctrl_hit;
    wire [7:0] ctrl_read;
    wire [1:0] flags;
    wire [1:0] flag_set;
    wire [1:0] flag_clr;

    // ************************************************************
    // Helpers
    // ************************************************************
    function [7:0] pack_ctrl;
        input       m;
        input       r;
        input [1:0] l;
        input [1:0] o;
        input       b1;
        input       b0;
        begin
            pack_ctrl = {m, r, l, o, b1, b0};
        end
    endfunction

    // Only the word address matters; the byte offset within it is ignored
    function is_ctrl;
        input [3:0] a;
        begin
            is_ctrl = (a[3:2] == `CTRL_OFFSET >> 2);
        end
    endfunction

    function is_stat;
        input [3:0] a;
        begin
            is_stat = (a[3:2] == `STAT_OFFSET >> 2);
        end
    endfunction

    // Reserved select 11 watches no edge at all
    function edge_wanted;
        input [1:0] sel;
        input       rising;
        begin
            edge_wanted = (sel == 2'b10) || (sel == {1'b0, rising}); // [R5]
        end
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // Single outstanding write: channels close until the response is taken
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign ctrl_hit      = is_ctrl(aw_addr);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            aw_addr      <= 4'h0;
            w_held       <= 1'b0;
            w_byte       <= 8'h00;
            w_lane       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                // Lane 0 carries the whole register; other lanes are ignored
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Writes to status answer OKAY but change nothing
                s_axi_bresp  <= (ctrl_hit || is_stat(aw_addr)) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode      <= 1'b0; // [R1]
            route     <= 1'b0;
            logic_sel <= 2'b00;
            out_sel   <= 2'b00;
            bit1_tx   <= 1'b0;
            bit0_tx   <= 1'b0;
        end
        else if (do_write && ctrl_hit && w_lane)
        begin
            mode      <= w_byte[`BIT_MODE]; // [R1]
            route     <= w_byte[`BIT_ROUTE];
            logic_sel <= w_byte[`BIT_LOGIC_HI:`BIT_LOGIC_LO];
            // Writing 00 here sends the sequencer back to idle
            out_sel   <= w_byte[`BIT_OUTF_HI:`BIT_OUTF_LO]; // [R14]
            // Low bits are plain storage only when the write lands in transmit
            if (!w_byte[`BIT_MODE])
            begin
                bit1_tx <= w_byte[`BIT_RISE]; // [R8]
                bit0_tx <= w_byte[`BIT_FALL]; // [R10]
            end
        end
    end

    // ************************************************************
    // Demodulation input path
    // ************************************************************
    assign demod_raw = route ? demod_input_pin_b : demod_input_pin_a; // [R3]

    // Bypassed in transmit so the edge history keeps following the pin
    glitch_filter #(
        .CW (4)
    ) u_filter (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .raw_in     (demod_raw),
        .filter_sel (mode ? out_sel : 2'b00), // [R7]
        .clean_out  (filt_in)
    );

    assign rise_evt = mode && filt_in && !filt_last && edge_wanted(logic_sel, 1'b1); // [R5]
    assign fall_evt = mode && !filt_in && filt_last && edge_wanted(logic_sel, 1'b0); // [R5]

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            filt_last   <= 1'b0;
            demod_edge  <= 1'b0;
            demod_level <= 1'b0;
        end
        else
        begin
            filt_last   <= filt_in;
            demod_level <= filt_in;
            demod_edge  <= rise_evt || fall_evt;
        end
    end

    // ************************************************************
    // Edge flags
    // ************************************************************
    // Bit 1 keeps rising edges, bit 0 falling edges
    assign flag_set = {rise_evt, fall_evt};
    // Clears act only in demod mode; in transmit the same bits are start levels
    assign flag_clr = (do_write && ctrl_hit && w_lane && mode) ? w_byte[`BIT_RISE:`BIT_FALL] : 2'b00;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_flag
            reg flag;

            // A new edge wins over a clear in the same cycle
            always @(posedge aclk)
            begin
                if (!aresetn)
                    flag <= 1'b0;
                else if (flag_set[g])
                    flag <= 1'b1; // [R9] [R11]
                else if (flag_clr[g])
                    flag <= 1'b0; // [R9] [R11]
            end
            assign flags[g] = flag;
        end
    endgenerate

    // ************************************************************
    // Transmit output path
    // ************************************************************
    always @*
    begin
        case (logic_sel)
            2'b00:   combined = short_timer_output & long_timer_output;    // [R4]
            2'b01:   combined = short_timer_output | long_timer_output;    // [R4]
            2'b10:   combined = ~(short_timer_output | long_timer_output); // [R4]
            default: combined = ~(short_timer_output & long_timer_output); // [R4]
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            carrier_output_pin     <= 1'b0;
            short_timer_init_level <= 1'b0;
            long_timer_init_level  <= 1'b0;
            long_force_en          <= 1'b0;
            long_force_level       <= 1'b0;
        end
        else
        begin
            // Registered so the pin does not glitch while the gate select changes
            carrier_output_pin     <= (!mode && route) ? combined : port_data_out; // [R2]
            short_timer_init_level <= bit1_tx; // [R8]
            long_timer_init_level  <= bit0_tx; // [R10]
            long_force_en          <= !mode && out_sel[1]; // [R6]
            long_force_level       <= out_sel[0]; // [R6]
        end
    end

    // ************************************************************
    // Ping-pong sequencer
    // ************************************************************
    // Sequencer depends on single-pass timers reporting done once per run
    assign ping_pong_active = !mode && (out_sel == 2'b01); // [R6] [R14]

    ping_pong_seq u_pp (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .active       (ping_pong_active),
        .short_done   (short_timer_done),
        .long_done    (long_timer_done),
        .short_enable (pp_short_enable),
        .long_enable  (pp_long_enable)
    );

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    // Low bits read as edge flags in demod mode, start levels in transmit
    assign ctrl_read = mode ? pack_ctrl(mode, route, logic_sel, out_sel, flags[1], flags[0])
                            : pack_ctrl(mode, route, logic_sel, out_sel, bit1_tx, bit0_tx);
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (is_ctrl(s_axi_araddr))
                s_axi_rdata <= {24'h00_0000, ctrl_read};
            else if (is_stat(s_axi_araddr))
                // Status lets software see the timers idle before a mode change
                s_axi_rdata <= {28'h000_0000, pp_long_enable, pp_short_enable, demod_level, mode}; // [R12]
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// ===== ir_timer_common_control_test.sv
// Self-checking bench of the common timer control block
`timescale 1ns/1ps
`include "ir_ctrl_consts.vh"
module ir_timer_common_control_test;
    reg         aclk, aresetn, awv, wv, bry, arv, rry, s_out, l_out, s_dn, l_dn, p_out;
    reg  [3:0]  awa, ara;
    reg  [31:0] wd, d;
    reg  [1:0]  rs;
    wire        awr, wr, bv, arr, rv, pin_a, pin_b, car, s_ini, l_ini, f_en, f_lv, pp, pp_s, pp_l, edg, lvl;
    wire [1:0]  br, rr;
    wire [31:0] rd;
    integer     err_total, n_tests, i, t;
    integer     n_edge = 0;
    ir_timer_common_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .short_timer_output(s_out), .long_timer_output(l_out), .short_timer_done(s_dn),
        .long_timer_done(l_dn), .port_data_out(p_out), .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b),
        .carrier_output_pin(car), .short_timer_init_level(s_ini), .long_timer_init_level(l_ini),
        .long_force_en(f_en), .long_force_level(f_lv), .ping_pong_active(pp), .pp_short_enable(pp_s),
        .pp_long_enable(pp_l), .demod_edge(edg), .demod_level(lvl));
    ir_pin_partner u_pins (.aclk(aclk), .pin_a(pin_a), .pin_b(pin_b));
    // Demod edge pulses, counted for the scenarios
    always @(posedge aclk)
    begin
        if (edg)
            n_edge <= n_edge + 1;
    end
    // ************************************************
    // Checking and bus tasks
    // ************************************************
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Bounded waits: a silent slave ends the run
    task bus(input wnr, input [3:0] a, input [7:0] v);
        integer k;
        begin
            @(posedge aclk);
            if (wnr) {awa, wd, awv, wv, bry} <= {a, 24'h0, v, 3'b111};
            else {ara, arv, rry} <= {a, 2'b11};
            for (k = 0; k < 40; k = k + 1)
            begin
                @(posedge aclk);
                if (awv && awr) awv <= 1'b0;
                if (wv && wr) wv <= 1'b0;
                if (arv && arr) arv <= 1'b0;
                if (wnr && bv)
                begin
                    rs = br;
                    bry <= 1'b0;
                    k = 99;
                end
                if (!wnr && rv)
                begin
                    d = rd;
                    rs = rr;
                    rry <= 1'b0;
                    k = 99;
                end
            end
            if (k < 99) check("timeout", 1, 0);
            if (k < 99) tally_and_finish;
        end
    endtask
    task wr_ok(input [7:0] v);
        begin
            bus(1, `CTRL_OFFSET, v);
            check("bresp", rs, `RESP_OKAY);
        end
    endtask
    task rd_chk(input [7:0] exp);
        begin
            bus(0, `CTRL_OFFSET, 0);
            check("ctrl", d, {24'h0, exp});
        end
    endtask
    function gate(input [1:0] l, input s, input g);
        gate = l[1] ^ ((l[1] ^ l[0]) ? (s | g) : (s & g));
    endfunction
    // ************************************************
    // Scenarios
    // ************************************************
    task sc_transmit;
        begin
            rd_chk(`CTRL_RESET);
            for (i = 0; i < 4; i = i + 1)
            begin
                wr_ok({2'b01, i[1:0], 4'h0});
                for (t = 0; t < 4; t = t + 1)
                begin
                    {s_out, l_out} <= t[1:0];
                    repeat (3) @(posedge aclk);
                    check("carrier", car, gate(i[1:0], t[1], t[0]));
                end
            end
            wr_ok(8'h00);
            for (t = 0; t < 2; t = t + 1)
            begin
                p_out <= t[0];
                repeat (3) @(posedge aclk);
                check("port out", car, t[0]);
            end
        end
    endtask
    task lv(input [7:0] v);
        begin
            wr_ok(v);
            rd_chk(v);
            check("levels", {s_ini, l_ini, f_en}, {v[1:0], v[3]});
            if (v[3]) check("force", f_lv, v[2]);
        end
    endtask
    task sc_pingpong;
        begin
            wr_ok(8'h04);
            check("pp on", {pp, pp_s, pp_l}, 3'b100);
            t = 1;
            while (t < 3)
            begin
                @(posedge aclk);
                {s_dn, l_dn} <= {t == 1, t == 2} & {2{t < 3}};
                @(posedge aclk);
                {s_dn, l_dn} <= 2'b00;
                repeat (2) @(posedge aclk);
                check("pp hand", {pp_s, pp_l}, t == 1 ? 2'b01 : 2'b10);
                t = t + 1;
            end
            wr_ok(8'h00);
            check("pp off", pp, 0);
        end
    endtask
    task dm(input r, input [1:0] e, input [1:0] f, input sel, input integer w, input [1:0] ex);
        integer c0;
        begin
            wr_ok({1'b1, r, e, f, 2'b11});
            repeat (20) @(posedge aclk);
            wr_ok({1'b1, r, e, f, 2'b11});
            c0 = n_edge;
            u_pins.pulse(sel, w);
            repeat (20) @(posedge aclk);
            rd_chk({1'b1, r, e, f, ex});
            check("edges", n_edge - c0, {1'b0, ex[1]} + ex[0]);
            check("level", lvl, 1);
            bus(0, `STAT_OFFSET, 0);
            check("status", d, 32'h3);
        end
    endtask
    initial
    begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    initial
    begin
        {aresetn, awv, wv, bry, arv, rry, s_out, l_out, s_dn, l_dn, p_out} = 0;
        {awa, ara, wd, err_total, n_tests} = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        sc_transmit;
        lv(8'h0a);
        lv(8'h0d);
        lv(8'h04);
        sc_pingpong;
        bus(1, 4'hc, 8'hff);
        check("bad wr", rs, `RESP_SLVERR);
        bus(0, 4'hc, 0);
        check("bad rd", d, 32'h0);
        check("bad rresp", rs, `RESP_SLVERR);
        dm(0, 2'b00, 2'b00, 0, 4, 2'b01);
        dm(1, 2'b01, 2'b00, 1, 4, 2'b10);
        dm(0, 2'b11, 2'b00, 0, 4, 2'b00);
        dm(1, 2'b10, 2'b00, 0, 4, 2'b00);
        dm(0, 2'b10, 2'b01, 0, 2, 2'b00);
        dm(1, 2'b10, 2'b10, 1, 6, 2'b00);
        dm(1, 2'b10, 2'b01, 1, 6, 2'b11);
        dm(0, 2'b10, 2'b10, 0, 12, 2'b11);
        wr_ok(8'ha8);
        rd_chk(8'hab);
        wr_ok(8'ha9);
        rd_chk(8'haa);
        tally_and_finish;
    end
endmodule
bind ir_timer_common_control ir_ctrl_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .short_timer_done(short_timer_done), .long_timer_done(long_timer_done),
    .ping_pong_active(ping_pong_active), .pp_short_enable(pp_short_enable),
    .pp_long_enable(pp_long_enable), .long_force_en(long_force_en));

// ===== ping_pong_seq.v
// Ping-pong sequencer that hands the run between the two timers
`timescale 1ns/1ps
module ping_pong_seq (
    input  wire aclk,
    input  wire aresetn,
    input  wire active,
    input  wire short_done,
    input  wire long_done,
    output reg  short_enable,
    output reg  long_enable
);
    always @(posedge aclk)
    begin
        if (!aresetn || !active)
        begin
            short_enable <= 1'b0;
            long_enable  <= 1'b0;
        end
        else if (short_done)
        begin
            short_enable <= 1'b0; // [R13]
            long_enable  <= 1'b1; // [R13]
        end
        else if (long_done)
        begin
            long_enable  <= 1'b0; // [R13]
            short_enable <= 1'b1; // [R13]
        end
    end
endmodule
